// ### inc/piaar_pkg.sv
package piaar_pkg;

  // Management register bus geometry
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned OUI_W    = 24;
  localparam int unsigned MODEL_W  = 6;
  localparam int unsigned REV_W    = 4;
  localparam int unsigned ABIL_W   = 4;
  localparam int unsigned SEL_W    = 5;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_VENDOR_IDENT_HIGH    = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_VENDOR_IDENT_LOW     = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_LOCAL_ABILITY_ADVERT = 5'h04;

  // Identity values; all three are arbitrary neutral codes
  localparam logic [OUI_W-1:0]   ORG_IDENT_DEFAULT   = 24'h5A3C96;
  localparam logic [MODEL_W-1:0] MODEL_NUM_DEFAULT   = 6'h15;
  localparam logic [REV_W-1:0]   REVISION_DEFAULT    = 4'h3;

  // Organizational identifier slicing (standard bit 1 is vector MSB)
  localparam int unsigned OUI_UPPER_MSB = 21;
  localparam int unsigned OUI_UPPER_LSB = 6;
  localparam int unsigned OUI_LOWER_MSB = 5;
  localparam int unsigned OUI_LOWER_LSB = 0;

  // Identifier low register field positions
  localparam int unsigned IDL_ORG_IDENT_LOWER_FIELD   = 10;
  localparam int unsigned IDL_MODEL_LSB = 4;
  localparam int unsigned IDL_REV_LSB   = 0;

  // Advertisement register field positions
  localparam int unsigned ADV_NEXT_PAGE   = 15;
  localparam int unsigned ADV_RSVD_IEEE   = 14;
  localparam int unsigned ADV_REMOTE_FLT  = 13;
  localparam int unsigned ADV_RSVD_FUTURE = 12;
  localparam int unsigned ADV_ASYM_PAUSE  = 11;
  localparam int unsigned ADV_PAUSE       = 10;
  localparam int unsigned ADV_FOUR_PAIR   = 9;
  localparam int unsigned ADV_ABIL_LSB    = 5;
  localparam int unsigned ADV_SEL_LSB     = 0;

  // Advertisement reset values
  localparam logic              NEXT_PAGE_RST   = 1'h0;
  localparam logic              REMOTE_FLT_RST  = 1'h0;
  localparam logic              ASYM_PAUSE_RST  = 1'h0;
  localparam logic              PAUSE_RST       = 1'h0;
  localparam logic              FOUR_PAIR_VALUE = 1'h0;
  localparam logic              RSVD_VALUE      = 1'h0;
  localparam logic [SEL_W-1:0]  SELECTOR_RST    = 5'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO       = 16'h0000;

endpackage

// ### inc/piaar_strap_if.sv
`timescale 1ns/1ps
interface piaar_strap_if;
  import piaar_pkg::*;
  logic [ABIL_W-1:0] ability;
  modport src (output ability);
  modport dst (input ability);
endinterface

// ### rtl/piaar_strap_sync.sv
`timescale 1ns/1ps
module piaar_strap_sync
  import piaar_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Strap pins, asynchronous
  input  wire logic [ABIL_W-1:0] strap_ability,
  // Synchronised strap levels
  piaar_strap_if.src             strap
);

  typedef struct packed {
    logic [ABIL_W-1:0] stage1;
    logic [ABIL_W-1:0] stage2;
  } piaar_sync_t;

  piaar_sync_t sync_q;
  piaar_sync_t sync_d;

  always_comb begin
    sync_d        = sync_q;
    sync_d.stage1 = strap_ability;
    sync_d.stage2 = sync_q.stage1;
  end

  always_ff @(posedge clk) begin
    sync_q <= sync_d;
  end

  assign strap.ability = sync_q.stage2;

endmodule

// ### rtl/piaar_regs.sv
`timescale 1ns/1ps
// Function
// - Identifier high returns organizational identifier bits 3 to 18 in 15:0.
// - Identifier bits 1 and 2 are dropped from both identifier registers.
// - Identifier low bits 15:10 return identifier bits 19 to 24 in order.
// - Identifier low bits 9:4 return a fixed six-bit model number.
// - Identifier low bits 3:0 return a fixed four-bit revision number.
// - Advertisement register is the ability word offered to the partner.
// - Bit 15 next page request, read-write, resets to zero.
// - Bit 14 reserved: writes ignored, reads zero.
// - Bit 13 remote fault advertisement, read-write, resets to zero.
// - Bit 12 reserved: manager writes zero, device reads zero.
// - Bit 11 asymmetric pause advertisement, read-write, resets to zero.
// - Bit 10 pause advertisement, read-write, resets to zero.
// - Bit 9 four-pair ability reads fixed zero.
// - Bits 8:5 ability bits, read-write, reset from straps.
// - Bits 4:0 protocol selector, read-write, resets to 00001.
module piaar_regs
  import piaar_pkg::*;
#(
  parameter logic [OUI_W-1:0]   ORG_IDENT = ORG_IDENT_DEFAULT,
  parameter logic [MODEL_W-1:0] MODEL_NUM = MODEL_NUM_DEFAULT,
  parameter logic [REV_W-1:0]   REVISION  = REVISION_DEFAULT
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Strap pins for ability reset values
  input  wire logic [ABIL_W-1:0] strap_ability,
  // Management register access
  input  wire logic [ADDR_W-1:0] mgmt_addr,
  input  wire logic              mgmt_rd,
  input  wire logic              mgmt_wr,
  input  wire logic [DATA_W-1:0] mgmt_wdata,
  output logic      [DATA_W-1:0] mgmt_rdata_q,
  output logic                   mgmt_rvalid_q,
  output logic                   mgmt_wack_q,
  // Ability word toward auto-negotiation
  output logic      [DATA_W-1:0] adv_word_q,
  output logic                   adv_update_q
);

  typedef struct packed {
    logic              next_page_request;
    logic              remote_fault_advert;
    logic              asymmetric_pause_advert;
    logic              pause_advert;
    logic              fast_full_duplex_ability;
    logic              fast_ability;
    logic              ten_full_duplex_ability;
    logic              ten_ability;
    logic [SEL_W-1:0]  selector;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              wack;
    logic [DATA_W-1:0] adv_word;
    logic              adv_update;
  } piaar_state_t;

  piaar_state_t state_q;
  piaar_state_t state_d;

  piaar_strap_if strap ();

  piaar_strap_sync u_strap_sync (
    .clk           (clk),
    .strap_ability (strap_ability),
    .strap         (strap)
  );

  // Upper identifier word, standard bits 1 and 2 discarded
  function automatic logic [DATA_W-1:0] ident_high_word(
    input logic [OUI_W-1:0] oui
  );
    ident_high_word = oui[OUI_UPPER_MSB:OUI_UPPER_LSB];
  endfunction

  function automatic logic [DATA_W-1:0] ident_low_word(
    input logic [OUI_W-1:0]   oui,
    input logic [MODEL_W-1:0] model,
    input logic [REV_W-1:0]   rev
  );
    logic [DATA_W-1:0] w;
    w = DATA_ZERO;
    w[IDL_ORG_IDENT_LOWER_FIELD +: (OUI_LOWER_MSB - OUI_LOWER_LSB + 1)] =
      oui[OUI_LOWER_MSB:OUI_LOWER_LSB];
    w[IDL_MODEL_LSB +: MODEL_W] = model;
    w[IDL_REV_LSB +: REV_W]     = rev;
    ident_low_word = w;
  endfunction

  // Builds the ability word from the stored fields
  function automatic logic [DATA_W-1:0] advert_word(
    input piaar_state_t s
  );
    logic [DATA_W-1:0] w;
    w = DATA_ZERO;
    w[ADV_NEXT_PAGE]   = s.next_page_request;
    w[ADV_RSVD_IEEE]   = RSVD_VALUE;
    w[ADV_REMOTE_FLT]  = s.remote_fault_advert;
    w[ADV_RSVD_FUTURE] = RSVD_VALUE;
    w[ADV_ASYM_PAUSE]  = s.asymmetric_pause_advert;
    w[ADV_PAUSE]       = s.pause_advert;
    w[ADV_FOUR_PAIR]   = FOUR_PAIR_VALUE;
    w[ADV_ABIL_LSB +: ABIL_W] = {s.fast_full_duplex_ability,
                                 s.fast_ability,
                                 s.ten_full_duplex_ability,
                                 s.ten_ability};
    w[ADV_SEL_LSB +: SEL_W] = s.selector;
    advert_word = w;
  endfunction

  // Read decode; unmapped addresses read zero
  function automatic logic [DATA_W-1:0] reg_read(
    input logic [ADDR_W-1:0] addr,
    input piaar_state_t      s
  );
    case (addr)
      ADDR_VENDOR_IDENT_HIGH:    reg_read = ident_high_word(ORG_IDENT);
      ADDR_VENDOR_IDENT_LOW:     reg_read = ident_low_word(ORG_IDENT,
                                              MODEL_NUM, REVISION);
      ADDR_LOCAL_ABILITY_ADVERT: reg_read = advert_word(s);
      default:                   reg_read = DATA_ZERO;
    endcase
  endfunction

  // Pulses last one cycle unless raised again
  function automatic piaar_state_t clear_pulses(
    input piaar_state_t s
  );
    piaar_state_t r;
    r            = s;
    r.rvalid     = 1'h0;
    r.wack       = 1'h0;
    r.adv_update = 1'h0;
    clear_pulses = r;
  endfunction

  // Only writable address in this slice
  function automatic logic is_advert_addr(
    input logic [ADDR_W-1:0] addr
  );
    is_advert_addr = (addr == ADDR_LOCAL_ABILITY_ADVERT);
  endfunction

  // Read answer is taken from the stored fields or the fixed identifier values
  function automatic piaar_state_t read_answer(
    input piaar_state_t      s,
    input logic [ADDR_W-1:0] addr
  );
    piaar_state_t r;
    r           = s;
    r.rdata     = reg_read(addr, s);
    r.rvalid    = 1'h1;
    read_answer = r;
  endfunction

  // Reserved and fixed positions are not stored, so writes there vanish
  function automatic piaar_state_t load_advert(
    input piaar_state_t      s,
    input logic [DATA_W-1:0] wdata
  );
    piaar_state_t r;
    r                         = s;
    r.next_page_request       = wdata[ADV_NEXT_PAGE];
    r.remote_fault_advert     = wdata[ADV_REMOTE_FLT];
    r.asymmetric_pause_advert = wdata[ADV_ASYM_PAUSE];
    r.pause_advert            = wdata[ADV_PAUSE];
    {r.fast_full_duplex_ability,
     r.fast_ability,
     r.ten_full_duplex_ability,
     r.ten_ability}           = wdata[ADV_ABIL_LSB +: ABIL_W];
    r.selector                = wdata[ADV_SEL_LSB +: SEL_W];
    load_advert               = r;
  endfunction

  // Every write is acknowledged; identifier addresses take no data
  function automatic piaar_state_t write_answer(
    input piaar_state_t      s,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wdata
  );
    piaar_state_t r;
    r      = s;
    r.wack = 1'h1;
    if (is_advert_addr(addr)) begin
      r            = load_advert(r, wdata);
      r.adv_update = 1'h1;
    end
    write_answer = r;
  endfunction

  // Reset image: fixed defaults plus the strap levels for the abilities
  function automatic piaar_state_t reset_state(
    input piaar_state_t      s,
    input logic [ABIL_W-1:0] ab
  );
    piaar_state_t r;
    r                         = clear_pulses(s);
    r.next_page_request       = NEXT_PAGE_RST;
    r.remote_fault_advert     = REMOTE_FLT_RST;
    r.asymmetric_pause_advert = ASYM_PAUSE_RST;
    r.pause_advert            = PAUSE_RST;
    {r.fast_full_duplex_ability,
     r.fast_ability,
     r.ten_full_duplex_ability,
     r.ten_ability}           = ab;
    r.selector                = SELECTOR_RST;
    r.rdata                   = DATA_ZERO;
    reset_state               = r;
  endfunction

  always_comb begin
    state_d = clear_pulses(state_q);

    // Read returns the value held before a same-cycle write
    if (mgmt_rd) begin
      state_d = read_answer(state_d, mgmt_addr);
    end

    if (mgmt_wr) begin
      state_d = write_answer(state_d, mgmt_addr, mgmt_wdata);
    end

    // Straps track the synchronised pins while reset is held
    if (srst) begin
      state_d = reset_state(state_d, strap.ability);
    end

    state_d.adv_word = advert_word(state_d);
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign mgmt_rdata_q  = state_q.rdata;
  assign mgmt_rvalid_q = state_q.rvalid;
  assign mgmt_wack_q   = state_q.wack;
  assign adv_word_q    = state_q.adv_word;
  assign adv_update_q  = state_q.adv_update;

endmodule

// ### test/piaar_regs_props.sv
`timescale 1ns/1ps
module piaar_regs_props
  import piaar_pkg::*;
#(
  parameter logic [OUI_W-1:0]   ORG_IDENT = ORG_IDENT_DEFAULT,
  parameter logic [MODEL_W-1:0] MODEL_NUM = MODEL_NUM_DEFAULT,
  parameter logic [REV_W-1:0]   REVISION  = REVISION_DEFAULT
)
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // Register access
  input wire logic [ADDR_W-1:0] mgmt_addr,
  input wire logic              mgmt_rd,
  input wire logic              mgmt_wr,
  input wire logic [DATA_W-1:0] mgmt_wdata,
  input wire logic [DATA_W-1:0] mgmt_rdata_q,
  input wire logic              mgmt_rvalid_q,
  input wire logic              mgmt_wack_q,
  // Ability word
  input wire logic [DATA_W-1:0] adv_word_q,
  input wire logic              adv_update_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid_q)
    else $error("read not answered");
  a_write_answer: assert property (mgmt_wr |=> mgmt_wack_q)
    else $error("write not acknowledged");
  a_ident_high: assert property (
    mgmt_rd && mgmt_addr == ADDR_VENDOR_IDENT_HIGH |=>
    mgmt_rdata_q == ORG_IDENT[21:6])
    else $error("bad identifier high");
  a_ident_low: assert property (
    mgmt_rd && mgmt_addr == ADDR_VENDOR_IDENT_LOW |=>
    mgmt_rdata_q == {ORG_IDENT[5:0], MODEL_NUM, REVISION})
    else $error("bad identifier low");
  a_reserved_zero: assert property (
    !adv_word_q[14] && !adv_word_q[12] && !adv_word_q[9])
    else $error("fixed bit set");
  a_advert_write: assert property (
    mgmt_wr && mgmt_addr == ADDR_LOCAL_ABILITY_ADVERT |=> adv_update_q &&
    adv_word_q == ($past(mgmt_wdata) & 16'hADFF))
    else $error("bad advert write");
  a_advert_read: assert property (
    mgmt_rd && !mgmt_wr && mgmt_addr == ADDR_LOCAL_ABILITY_ADVERT |=>
    mgmt_rdata_q == adv_word_q)
    else $error("read differs from advert");
  a_other_write: assert property (
    mgmt_wr && mgmt_addr != ADDR_LOCAL_ABILITY_ADVERT |=>
    $stable(adv_word_q) && !adv_update_q)
    else $error("stray change");
endmodule
bind piaar_regs piaar_regs_props #(.ORG_IDENT(ORG_IDENT),
  .MODEL_NUM(MODEL_NUM), .REVISION(REVISION)) u_piaar_regs_props (
  .clk(clk), .srst(srst), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
  .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_q(mgmt_rdata_q),
  .mgmt_rvalid_q(mgmt_rvalid_q), .mgmt_wack_q(mgmt_wack_q),
  .adv_word_q(adv_word_q), .adv_update_q(adv_update_q));

// ### test/piaar_mgmt_model.sv
`timescale 1ns/1ps
module piaar_mgmt_model
  import piaar_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Requests
  output logic      [ADDR_W-1:0] addr,
  output logic                   rd,
  output logic                   wr,
  output logic      [DATA_W-1:0] wdata,
  // Answers
  input  wire logic [DATA_W-1:0] rdata_q,
  input  wire logic              rvalid_q,
  input  wire logic              wack_q
);
  initial begin
    addr = 5'h00;
    rd = 1'h0;
    wr = 1'h0;
    wdata = 16'h0000;
  end
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic ok);
    @(negedge clk);
    addr = a;
    wdata = d & 16'hEFFF;
    wr = 1'h1;
    @(negedge clk);
    ok = (wack_q === 1'h1);
    wr = 1'h0;
    wdata = ~wdata;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d, output logic ok);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    ok = (rvalid_q === 1'h1);
    d = rdata_q;
    rd = 1'h0;
  endtask
endmodule

// ### test/test_phy_ident_and_an_advert_regs.sv
`timescale 1ns/1ps
module test_phy_ident_and_an_advert_regs;
  import piaar_pkg::*;
  logic              clk;
  logic              srst;
  logic [ABIL_W-1:0] strap;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic              wack;
  logic [DATA_W-1:0] adv;
  logic              upd;
  int                fails = 0;
  int                checks = 0;
  localparam logic [DATA_W-1:0] ID_HI = ORG_IDENT_DEFAULT[21:6];
  localparam logic [DATA_W-1:0] ID_LO = {ORG_IDENT_DEFAULT[5:0],
                                         MODEL_NUM_DEFAULT, REVISION_DEFAULT};
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  piaar_regs u_piaar_regs (.clk(clk), .srst(srst), .strap_ability(strap),
    .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr), .mgmt_wdata(wdata),
    .mgmt_rdata_q(rdata), .mgmt_rvalid_q(rvalid), .mgmt_wack_q(wack),
    .adv_word_q(adv), .adv_update_q(upd));
  piaar_mgmt_model u_piaar_mgmt_model (.clk(clk), .addr(addr), .rd(rd),
    .wr(wr), .wdata(wdata), .rdata_q(rdata), .rvalid_q(rvalid),
    .wack_q(wack));
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic              ok;
    u_piaar_mgmt_model.rd_reg(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, e);
  endtask
  task automatic wr_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    logic ok;
    u_piaar_mgmt_model.wr_reg(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({15'h0000, upd}, {15'h0000, a == ADDR_LOCAL_ABILITY_ADVERT});
  endtask
  task automatic do_reset(input logic [ABIL_W-1:0] s);
    srst = 1'h1;
    strap = s;
    repeat (20) @(negedge clk);
    srst = 1'h0;
  endtask
  task automatic t_reset_values;
    rd_chk(5'h04, 16'h0141);
    chk(adv, 16'h0141);
    rd_chk(5'h02, ID_HI);
    rd_chk(5'h03, ID_LO);
  endtask
  task automatic t_advert_rw;
    wr_chk(5'h04, 16'hFFFF);
    chk(adv, 16'hADFF);
    rd_chk(5'h04, 16'hADFF);
    wr_chk(5'h04, 16'h5200);
    rd_chk(5'h04, 16'h0000);
  endtask
  task automatic t_ident_write;
    wr_chk(5'h02, 16'h0000);
    wr_chk(5'h03, 16'hFFFF);
    wr_chk(5'h1F, 16'hFFFF);
    rd_chk(5'h02, ID_HI);
    rd_chk(5'h03, ID_LO);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(5'h04, 16'h0000);
  endtask
  task automatic t_strap_reset;
    do_reset(4'h5);
    rd_chk(5'h04, 16'h00A1);
    chk(adv, 16'h00A1);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    fails++;
    close_out;
  end
  initial begin
    do_reset(4'hA);
    t_reset_values;
    t_advert_rw;
    t_ident_write;
    t_strap_reset;
    close_out;
  end
endmodule
